// [pwr_seq_pkg.sv]
package pwr_seq_pkg;

   // Millisecond timebase derived from the 10 MHz core clock.
   localparam int CLK_PERIOD_NS = 100;
   localparam int MS_PERIOD_NS = 1000000;
   localparam int CYCLES_PER_MS = MS_PERIOD_NS / CLK_PERIOD_NS;

   // All sequencing times are counted in milliseconds.
   localparam int MS_W = 14;
   localparam int MODE_W = 4;
   localparam int MODE_RESERVED_BIT = 3;
   localparam logic [MS_W-1:0] DEBOUNCE_MS = MS_W'(10);
   localparam logic [MS_W-1:0] RESET_PULSE_MS = MS_W'(10);
   localparam logic [MS_W-1:0] HARD_OFF_MS = MS_W'(50);
   localparam logic [MS_W-1:0] TRIGGER_DELAY_MS = MS_W'(200);
   localparam logic [MS_W-1:0] SHUTDOWN_DELAY_MS = MS_W'(30);
   localparam logic [MS_W-1:0] FIRST_POINT_MS = MS_W'(34);
   localparam int KEY_ON_S = 3;
   localparam int KEY_SOFT_S = 12;
   localparam logic [MS_W-1:0] KEY_ON_MS = MS_W'(KEY_ON_S * 1000);
   localparam logic [MS_W-1:0] KEY_SOFT_MS = MS_W'(KEY_SOFT_S * 1000);
   localparam logic [MS_W-1:0] RESET_DELAY_80_MS = MS_W'(80);
   localparam logic [MS_W-1:0] RESET_DELAY_120_MS = MS_W'(120);
   localparam logic [MS_W-1:0] RESET_DELAY_220_MS = MS_W'(220);
   localparam logic [MS_W-1:0] RESET_DELAY_420_MS = MS_W'(420);

   // Pin function modes.
   localparam logic [MODE_W-1:0] MODE_ON_HIGH = 4'h0;
   localparam logic [MODE_W-1:0] MODE_ON_LOW = 4'h1;
   localparam logic [MODE_W-1:0] MODE_EDGE_RISE = 4'h2;
   localparam logic [MODE_W-1:0] MODE_EDGE_FALL = 4'h3;
   localparam logic [MODE_W-1:0] MODE_CHG_HIGH = 4'h4;
   localparam logic [MODE_W-1:0] MODE_CHG_LOW = 4'h5;
   localparam logic [MODE_W-1:0] MODE_KEY_ONOFF = 4'h6;
   localparam logic [MODE_W-1:0] MODE_KEY_SOFT = 4'h7;

   // Regulator turn-on points.
   localparam logic [1:0] POINT_EARLY = 2'h0;
   localparam logic [1:0] POINT_MID1 = 2'h1;
   localparam logic [1:0] POINT_MID2 = 2'h2;
   localparam logic [1:0] POINT_RELEASE = 2'h3;

   typedef enum logic [2:0] {
      st_off,
      st_seq,
      st_on,
      st_trig_wait,
      st_hard_off,
      st_shut_wait
   } seq_state_t;

   function automatic logic [MS_W-1:0] reset_delay_ms(input logic [1:0] sel);
      case (sel)
         2'h0: reset_delay_ms = RESET_DELAY_80_MS;
         2'h1: reset_delay_ms = RESET_DELAY_120_MS;
         2'h2: reset_delay_ms = RESET_DELAY_220_MS;
         default: reset_delay_ms = RESET_DELAY_420_MS;
      endcase
   endfunction

endpackage

// [ms_timebase.sv]
`timescale 1ns/1ps
module ms_timebase #(
   parameter int CYCLES_PER_MS = pwr_seq_pkg::CYCLES_PER_MS
) (
   input wire logic i_core_clk,
   input wire logic i_arst_n,
   output logic o_tick
);
   import pwr_seq_pkg::*;

   typedef struct packed {
      logic [31:0] count;
      logic tick;
   } tb_t;

   tb_t cur;
   tb_t next_cur;

   always_comb begin
      next_cur = cur;
      next_cur.tick = 1'b0;
      if (cur.count >= 32'(CYCLES_PER_MS - 1)) begin
         next_cur.count = '0;
         next_cur.tick = 1'b1;
      end else begin
         next_cur.count = cur.count + 32'd1;
      end
   end

   always_ff @(posedge i_core_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         cur <= '0;
      end else begin
         cur <= next_cur;
      end
   end

   assign o_tick = cur.tick;

   tick_spacing_a: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
      (o_tick && CYCLES_PER_MS > 1) |=> !o_tick)
      else $error("Millisecond tick lasted more than one cycle.");
endmodule

// [pin_filter.sv]
`timescale 1ns/1ps
module pin_filter (
   input wire logic i_core_clk,
   input wire logic i_arst_n,
   input wire logic i_ms_tick,
   input wire logic i_pin,
   output logic o_level,
   output logic o_rise,
   output logic o_fall,
   output logic o_ready
);
   import pwr_seq_pkg::*;

   typedef struct packed {
      logic sync1;
      logic sync2;
      logic level;
      logic rise;
      logic fall;
      logic ready;
      logic [MS_W-1:0] count;
   } filt_t;

   filt_t cur;
   filt_t next_cur;

   always_comb begin
      next_cur = cur;
      next_cur.sync1 = i_pin;
      next_cur.sync2 = cur.sync1;
      next_cur.rise = 1'b0;
      next_cur.fall = 1'b0;
      // The first settled sample is taken without an edge, so idle pulled-up pins do not fake an event.
      if (!cur.ready) begin
         if (i_ms_tick) begin
            next_cur.level = cur.sync2;
            next_cur.ready = 1'b1;
         end
      end else if (cur.sync2 == cur.level) begin
         next_cur.count = '0;
      end else if (i_ms_tick) begin
         if (cur.count >= DEBOUNCE_MS - MS_W'(1)) begin
            next_cur.count = '0;
            next_cur.level = cur.sync2;
            next_cur.rise = cur.sync2;
            next_cur.fall = !cur.sync2;
         end else begin
            next_cur.count = cur.count + MS_W'(1);
         end
      end
   end

   always_ff @(posedge i_core_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         cur <= '0;
      end else begin
         cur <= next_cur;
      end
   end

   assign o_level = cur.level;
   assign o_rise = cur.rise;
   assign o_fall = cur.fall;
   assign o_ready = cur.ready;

   edge_level_a: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
      o_rise |-> (o_level && !$past(o_level)))
      else $error("Rising event without a settled high level.");
endmodule

// [power_fn_reset_sequencer.sv]
`timescale 1ns/1ps
module power_fn_reset_sequencer #(
   parameter int CYCLES_PER_MS = pwr_seq_pkg::CYCLES_PER_MS,
   parameter int NUM_REG = 5
) (
   input wire logic i_core_clk,
   input wire logic i_arst_n,
   input wire logic [pwr_seq_pkg::MODE_W-1:0] i_pin_function_select,
   input wire logic i_pin_bias_enable,
   input wire logic [1:0] i_reset_delay_sel,
   input wire logic [2*NUM_REG-1:0] i_reg_on_point,
   input wire logic [NUM_REG-1:0] i_reg_default_off,
   input wire logic [NUM_REG-1:0] i_reg_always_on,
   input wire logic [NUM_REG-1:0] i_reg_host_enable,
   input wire logic i_shutdown_request,
   input wire logic i_power_fn_in_a,
   input wire logic i_power_fn_io_b,
   input wire logic i_charger_input,
   input wire logic i_system_rail_uv,
   input wire logic i_system_rail_present,
   input wire logic i_battery_rail_present,
   output logic o_power_fn_io_b,
   output logic o_power_fn_io_b_oe,
   output logic o_pullup_a,
   output logic o_pulldown_a,
   output logic o_pullup_b,
   output logic o_pulldown_b,
   output logic o_system_rail_enable,
   output logic [NUM_REG-1:0] o_reg_enable,
   output logic o_reset_n,
   output logic o_config_reset
);
   import pwr_seq_pkg::*;

   typedef struct packed {
      seq_state_t state;
      logic [MS_W-1:0] ms_count;
      logic [MS_W-1:0] pulse_count;
      logic [MS_W-1:0] key_count;
      logic trig_hard;
      logic charger_s1;
      logic charger_s2;
      logic charger_prev;
      logic uv_s1;
      logic uv_s2;
      logic present_s1;
      logic present_s2;
      logic system_rail_enable;
      logic reset_n;
      logic config_reset;
      logic io_b;
      logic io_b_oe;
      logic pullup_a;
      logic pulldown_a;
      logic pullup_b;
      logic pulldown_b;
      logic [NUM_REG-1:0] reg_enable;
   } ctrl_t;

   ctrl_t cur, next_cur;
   logic ms_tick;
   logic [1:0] pin_level, pin_rise, pin_fall, pin_ready, pin_raw;

   // Turn-on point decode, shared by every regulator lane.
   function automatic logic point_reached(input logic [1:0] point, input logic [MS_W-1:0] ms,
                                          input logic [MS_W-1:0] delay);
      logic [MS_W-1:0] mark;
      mark = FIRST_POINT_MS;
      case (point)
         POINT_EARLY: mark = FIRST_POINT_MS;
         POINT_MID1: mark = FIRST_POINT_MS + (delay >> 2);
         POINT_MID2: mark = FIRST_POINT_MS + (delay >> 1);
         default: mark = FIRST_POINT_MS + delay;
      endcase
      point_reached = ms >= mark;
   endfunction

   ms_timebase #(
      .CYCLES_PER_MS(CYCLES_PER_MS)
   ) u_timebase (
      .i_core_clk(i_core_clk),
      .i_arst_n(i_arst_n),
      .o_tick(ms_tick)
   );

   assign pin_raw = {i_power_fn_io_b, i_power_fn_in_a};

   generate
      for (genvar p = 0; p < 2; p++) begin : g_pin
         pin_filter u_filter (
            .i_core_clk(i_core_clk),
            .i_arst_n(i_arst_n),
            .i_ms_tick(ms_tick),
            .i_pin(pin_raw[p]),
            .o_level(pin_level[p]),
            .o_rise(pin_rise[p]),
            .o_fall(pin_fall[p]),
            .o_ready(pin_ready[p])
         );
      end
   endgenerate

   always_comb begin
      logic [MODE_W-1:0] mode;
      logic on_off_mode, key_mode, delayed_mode, reserved, ready, enable_level, key_pressed, key_on_hit;
      logic key_soft_hit, charger_attach, hard_trig, soft_trig, shutdown_ok, start_pulse, powered, released;
      logic [MS_W-1:0] delay, ms_inc;
      mode = i_pin_function_select;
      on_off_mode = (mode == MODE_ON_HIGH) || (mode == MODE_ON_LOW);
      key_mode = (mode == MODE_KEY_ONOFF) || (mode == MODE_KEY_SOFT);
      delayed_mode = (mode >= MODE_EDGE_RISE) && (mode <= MODE_CHG_LOW);
      reserved = mode[MODE_RESERVED_BIT];
      ready = &pin_ready;
      enable_level = ready && ((mode == MODE_ON_HIGH) ? pin_level[0] : !pin_level[0]);
      key_pressed = ready && key_mode && !pin_level[0];
      delay = reset_delay_ms(i_reset_delay_sel);
      ms_inc = (ms_tick && cur.ms_count != '1) ? cur.ms_count + MS_W'(1) : cur.ms_count;
      next_cur = cur;
      next_cur.charger_s1 = i_charger_input;
      next_cur.charger_s2 = cur.charger_s1;
      next_cur.charger_prev = cur.charger_s2;
      next_cur.uv_s1 = i_system_rail_uv;
      next_cur.uv_s2 = cur.uv_s1;
      next_cur.present_s1 = i_system_rail_present || i_battery_rail_present;
      next_cur.present_s2 = cur.present_s1;
      next_cur.config_reset = 1'b0;
      charger_attach = cur.charger_s2 && !cur.charger_prev;
      // Key hold counter in milliseconds, saturating.
      if (!key_pressed) begin
         next_cur.key_count = '0;
      end else if (ms_tick && cur.key_count != '1) begin
         next_cur.key_count = cur.key_count + MS_W'(1);
      end
      key_on_hit = key_pressed && ms_tick && (cur.key_count == KEY_ON_MS - MS_W'(1));
      key_soft_hit = key_pressed && ms_tick && (cur.key_count == KEY_SOFT_MS - MS_W'(1));
      if (ms_tick && cur.pulse_count != '0) begin
         next_cur.pulse_count = cur.pulse_count - MS_W'(1);
      end
      hard_trig = 1'b0;
      soft_trig = 1'b0;
      case (mode)
         MODE_ON_HIGH, MODE_ON_LOW: begin
            soft_trig = ready && pin_fall[1];
         end
         MODE_EDGE_RISE: begin
            hard_trig = pin_rise[0];
            soft_trig = pin_rise[1];
         end
         MODE_EDGE_FALL: begin
            hard_trig = ready && pin_fall[0];
            soft_trig = ready && pin_fall[1];
         end
         MODE_CHG_HIGH: begin
            hard_trig = ready && charger_attach && pin_level[0];
            soft_trig = ready && charger_attach && pin_level[1];
         end
         MODE_CHG_LOW: begin
            hard_trig = ready && charger_attach && !pin_level[0];
            soft_trig = ready && charger_attach && !pin_level[1];
         end
         MODE_KEY_SOFT: begin
            soft_trig = key_soft_hit;
         end
         default: begin
            hard_trig = 1'b0;
            soft_trig = 1'b0;
         end
      endcase
      shutdown_ok = i_shutdown_request && !on_off_mode && !reserved;
      start_pulse = 1'b0;
      case (cur.state)
         st_off: begin
            next_cur.ms_count = '0;
            next_cur.pulse_count = '0;
            if ((on_off_mode && enable_level) || (!on_off_mode && !reserved && charger_attach)
                || key_on_hit) begin
               next_cur.state = st_seq;
            end
         end
         st_seq: begin
            next_cur.ms_count = ms_inc;
            if (cur.uv_s2) begin
               if (cur.charger_s2) begin
                  next_cur.ms_count = '0;
               end else begin
                  next_cur.state = st_off;
               end
            end else if (on_off_mode && !enable_level) begin
               next_cur.state = st_off;
            end else if (cur.ms_count >= FIRST_POINT_MS + delay) begin
               next_cur.state = st_on;
            end
         end
         st_on: begin
            if (cur.uv_s2) begin
               next_cur.state = st_off;
            end else if (on_off_mode && !enable_level) begin
               next_cur.state = st_off;
            end else if (shutdown_ok) begin
               next_cur.ms_count = '0;
               next_cur.state = (mode == MODE_KEY_SOFT) ? st_shut_wait : st_off;
            end else if (mode == MODE_KEY_ONOFF && key_on_hit) begin
               next_cur.state = st_off;
            end else if (delayed_mode && (hard_trig || soft_trig)) begin
               next_cur.ms_count = '0;
               next_cur.trig_hard = hard_trig;
               next_cur.state = st_trig_wait;
            end else if (soft_trig) begin
               start_pulse = 1'b1;
            end
         end
         st_trig_wait: begin
            next_cur.ms_count = ms_inc;
            if (cur.uv_s2) begin
               next_cur.state = st_off;
            end else if (shutdown_ok) begin
               next_cur.state = st_off;
            end else if (cur.ms_count >= TRIGGER_DELAY_MS) begin
               next_cur.ms_count = '0;
               if (cur.trig_hard) begin
                  next_cur.state = st_hard_off;
               end else begin
                  next_cur.state = st_on;
                  start_pulse = 1'b1;
               end
            end
         end
         st_hard_off: begin
            next_cur.ms_count = ms_inc;
            if (cur.ms_count >= HARD_OFF_MS) begin
               next_cur.ms_count = '0;
               next_cur.state = st_seq;
            end
         end
         st_shut_wait: begin
            next_cur.ms_count = ms_inc;
            if (cur.ms_count >= SHUTDOWN_DELAY_MS) begin
               next_cur.state = st_off;
            end
         end
         default: begin
            next_cur.state = st_off;
         end
      endcase
      if (start_pulse) begin
         next_cur.pulse_count = RESET_PULSE_MS;
         next_cur.config_reset = 1'b1;
      end
      powered = (next_cur.state == st_seq) || (next_cur.state == st_on) || (next_cur.state == st_trig_wait)
                || (next_cur.state == st_shut_wait);
      released = powered && (next_cur.state != st_seq);
      next_cur.system_rail_enable = powered;
      next_cur.reset_n = released && (next_cur.pulse_count == '0);
      for (int r = 0; r < NUM_REG; r++) begin
         next_cur.reg_enable[r] = (i_reg_always_on[r] && cur.present_s2)
            || (powered && !i_reg_default_off[r]
                && (released || point_reached(i_reg_on_point[2*r +: 2], next_cur.ms_count, delay)))
            || (released && i_reg_host_enable[r]);
      end
      // Bias network per mode; key-out drives actively so it gets no bias.
      next_cur.pullup_a = 1'b0;
      next_cur.pulldown_a = 1'b0;
      next_cur.pullup_b = 1'b0;
      next_cur.pulldown_b = 1'b0;
      if (i_pin_bias_enable && !reserved) begin
         case (mode)
            MODE_ON_HIGH: begin
               next_cur.pulldown_a = 1'b1;
               next_cur.pullup_b = 1'b1;
            end
            MODE_EDGE_RISE, MODE_CHG_HIGH: begin
               next_cur.pulldown_a = 1'b1;
               next_cur.pulldown_b = 1'b1;
            end
            MODE_KEY_ONOFF, MODE_KEY_SOFT: begin
               next_cur.pullup_a = 1'b1;
            end
            default: begin
               next_cur.pullup_a = 1'b1;
               next_cur.pullup_b = 1'b1;
            end
         endcase
      end
      next_cur.io_b_oe = key_mode;
      next_cur.io_b = key_mode && pin_level[0];
   end

   always_ff @(posedge i_core_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         cur <= '0;
      end else begin
         cur <= next_cur;
      end
   end

   assign o_power_fn_io_b = cur.io_b;
   assign o_power_fn_io_b_oe = cur.io_b_oe;
   assign o_pullup_a = cur.pullup_a;
   assign o_pulldown_a = cur.pulldown_a;
   assign o_pullup_b = cur.pullup_b;
   assign o_pulldown_b = cur.pulldown_b;
   assign o_system_rail_enable = cur.system_rail_enable;
   assign o_reg_enable = cur.reg_enable;
   assign o_reset_n = cur.reset_n;
   assign o_config_reset = cur.config_reset;

   soft_reset_low_a: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
      o_config_reset |-> !o_reset_n ##1 !o_reset_n)
      else $error("Soft reset did not hold reset low.");
   shutdown_ignored_a: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
      (cur.state == st_on && i_shutdown_request && i_pin_function_select <= MODE_ON_LOW && !cur.uv_s2
       && ((i_pin_function_select == MODE_ON_HIGH) == pin_level[0]) && (&pin_ready))
      |=> cur.state == st_on)
      else $error("Shutdown request acted in an on/off mode.");
   trig_delay_a: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
      (cur.state == st_trig_wait && cur.ms_count < TRIGGER_DELAY_MS)
      |=> (cur.state == st_trig_wait || cur.state == st_off))
      else $error("Triggered reset acted before its delay.");
   hard_off_a: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
      (cur.state == st_hard_off && cur.ms_count < HARD_OFF_MS) |=> !o_system_rail_enable)
      else $error("Power came back during hard reset off time.");
   reserved_quiet_a: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
      (i_pin_function_select[MODE_RESERVED_BIT] && cur.state == st_on) |=> cur.state != st_trig_wait)
      else $error("Reserved mode triggered a reset.");
   uv_off_a: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
      (cur.state == st_seq && cur.uv_s2 && !cur.charger_s2) |=> (cur.state == st_off && !o_system_rail_enable))
      else $error("Undervoltage without charger did not power off.");
   uv_restart_a: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
      (cur.state == st_seq && cur.uv_s2 && cur.charger_s2) |=> (cur.state == st_seq && cur.ms_count == '0))
      else $error("Undervoltage with charger did not restart the sequence.");
   seq_reset_a: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
      (cur.state == st_seq) |-> (!o_reset_n && o_system_rail_enable))
      else $error("Reset released during sequencing.");
endmodule

// [fn_pin_partner.sv]
`timescale 1ns/1ps
module fn_pin_partner (
   input wire logic i_core_clk,
   input wire logic i_drive_a,
   input wire logic i_level_a,
   input wire logic i_drive_b,
   input wire logic i_level_b,
   input wire logic i_pullup_a,
   input wire logic i_pulldown_a,
   input wire logic i_pullup_b,
   input wire logic i_pulldown_b,
   input wire logic i_key_out,
   input wire logic i_key_out_oe,
   output logic o_pin_a,
   output logic o_pin_b
);
   logic float_level = 1'b0;
   // A released pin with no bias wanders, so it is toggled rather than left at a settled value.
   always @(posedge i_core_clk) begin
      float_level <= ~float_level;
   end
   always_comb begin
      if (i_drive_a) o_pin_a = i_level_a;
      else if (i_pullup_a || i_pulldown_a) o_pin_a = i_pullup_a;
      else o_pin_a = float_level;
      if (i_key_out_oe) o_pin_b = i_key_out;
      else if (i_drive_b) o_pin_b = i_level_b;
      else if (i_pullup_b || i_pulldown_b) o_pin_b = i_pullup_b;
      else o_pin_b = ~float_level;
   end
endmodule

// [test_power_fn_reset_sequencer.sv]
`timescale 1ns/1ps
module test_power_fn_reset_sequencer;
   import pwr_seq_pkg::*;
   logic core_clk = 1'b0;
   logic arst_n = 1'b0;
   logic [3:0] mode = 4'h0;
   logic [1:0] delay_sel = 2'h0;
   logic [9:0] on_point = 10'h000;
   logic [4:0] default_off = 5'h00;
   logic [4:0] host_en = 5'h00;
   logic bias_en = 1'b1;
   logic shutdown = 1'b0, charger = 1'b0, uv = 1'b0;
   logic drive_a = 1'b0, level_a = 1'b0, drive_b = 1'b0, level_b = 1'b0;
   logic pin_a, pin_b, key_out, key_oe, pu_a, pd_a, pu_b, pd_b, rail_en, reset_n, cfg_rst;
   logic [4:0] reg_en;
   int n_errors = 0;
   int n_compared = 0;
   int n_cycles = 0;
   int n;
   int lo;
   initial forever #50 core_clk = ~core_clk;
   power_fn_reset_sequencer #(.CYCLES_PER_MS(10)) uut (.i_core_clk(core_clk), .i_arst_n(arst_n),
      .i_pin_function_select(mode), .i_pin_bias_enable(bias_en), .i_reset_delay_sel(delay_sel),
      .i_reg_on_point(on_point), .i_reg_default_off(default_off), .i_reg_always_on(5'h00),
      .i_reg_host_enable(host_en), .i_shutdown_request(shutdown), .i_power_fn_in_a(pin_a),
      .i_power_fn_io_b(pin_b), .i_charger_input(charger), .i_system_rail_uv(uv),
      .i_system_rail_present(1'b1), .i_battery_rail_present(1'b1), .o_power_fn_io_b(key_out),
      .o_power_fn_io_b_oe(key_oe), .o_pullup_a(pu_a), .o_pulldown_a(pd_a), .o_pullup_b(pu_b),
      .o_pulldown_b(pd_b), .o_system_rail_enable(rail_en), .o_reg_enable(reg_en), .o_reset_n(reset_n),
      .o_config_reset(cfg_rst));
   fn_pin_partner partner (.i_core_clk(core_clk), .i_drive_a(drive_a), .i_level_a(level_a),
      .i_drive_b(drive_b), .i_level_b(level_b), .i_pullup_a(pu_a), .i_pulldown_a(pd_a),
      .i_pullup_b(pu_b), .i_pulldown_b(pd_b), .i_key_out(key_out), .i_key_out_oe(key_oe),
      .o_pin_a(pin_a), .o_pin_b(pin_b));
   task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
      n_compared++;
      if (seen !== exp) begin
         n_errors++;
         $display("CHECK FAILED at %0t: %s seen %0h expected %0h", $time, what, seen, exp);
      end
   endtask
   task automatic cycles(input int k);
      repeat (k) @(negedge core_clk);
   endtask
   // Waits on the rail enable (which 0) or the reset output (which 1), bounded by limit cycles.
   task automatic wait_for(input int which, input logic want, input int limit, output int k);
      k = 0;
      while (((which == 0) ? rail_en : reset_n) !== want && k < limit) begin
         @(negedge core_clk);
         k++;
      end
      check(k < limit, 1'b1, "wait limit");
   endtask
   function automatic int delay_ms(input logic [1:0] s);
      return (s == 2'h0) ? 80 : (s == 2'h1) ? 120 : (s == 2'h2) ? 220 : 420;
   endfunction
   function automatic logic [4:0] early_mask();
      logic [4:0] m;
      for (int i = 0; i < 5; i++) begin
         m[i] = (on_point[2*i +: 2] == POINT_EARLY) && !default_off[i];
      end
      return m;
   endfunction
   task automatic print_verdict();
      $display("compared %0d, errors %0d", n_compared, n_errors);
      if (n_errors == 0 && n_compared > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   always @(posedge core_clk) begin
      n_cycles++;
      if (n_cycles == 40000) begin
         n_errors++;
         print_verdict();
      end
   end
   initial begin
      void'($urandom(46534));
      delay_sel = 2'($urandom);
      repeat (6) @(negedge core_clk);
      arst_n = 1'b1;
      mode = 4'h8 | 4'($urandom);
      drive_a = 1'b1;
      level_a = 1'b1;
      drive_b = 1'b1;
      cycles(300);
      check({pu_a, pd_a, pu_b, pd_b}, 4'h0, "reserved bias");
      check(rail_en, 1'b0, "reserved power");
      $display("reserved mode test done");
      mode = 4'h0;
      drive_a = 1'b0;
      drive_b = 1'b0;
      on_point = 10'($urandom);
      default_off = 5'($urandom);
      host_en = 5'($urandom);
      cycles(300);
      check({pu_a, pd_a, pu_b, pd_b}, 4'h6, "mode 0 bias");
      bias_en = 1'b0;
      cycles(2);
      check({pu_a, pd_a, pu_b, pd_b}, 4'h0, "bias disabled");
      bias_en = 1'b1;
      drive_a = 1'b1;
      wait_for(0, 1'b1, 200, n);
      check(n >= 95 && n <= 125, 1'b1, "debounce");
      cycles(360);
      check(reg_en, early_mask(), "early regs");
      wait_for(1, 1'b1, 6000, n);
      lo = 34 + delay_ms(delay_sel);
      check(n + 360 >= 10 * lo - 10 && n + 360 <= 10 * lo + 10, 1'b1, "reset delay");
      cycles(2);
      check(reg_en, 5'(~default_off | host_en), "release regs");
      shutdown = 1'b1;
      cycles(1);
      shutdown = 1'b0;
      cycles(500);
      check(rail_en, 1'b1, "shutdown ignored");
      drive_b = 1'b1;
      wait_for(1, 1'b0, 200, n);
      check(cfg_rst, 1'b1, "config reset");
      drive_b = 1'b0;
      wait_for(1, 1'b1, 200, n);
      check(n >= 85 && n <= 105, 1'b1, "reset pulse");
      uv = 1'b1;
      cycles(5);
      check({rail_en, reset_n}, 2'h0, "undervoltage");
      uv = 1'b0;
      cycles(5);
      check(rail_en, 1'b1, "power back on");
      uv = 1'b1;
      cycles(5);
      check(rail_en, 1'b0, "sequencing undervoltage");
      uv = 1'b0;
      drive_a = 1'b0;
      cycles(200);
      check(rail_en, 1'b0, "pin off");
      $display("mode 0 test done");
      mode = 4'h2;
      charger = 1'b1;
      wait_for(0, 1'b1, 100, n);
      uv = 1'b1;
      cycles(4);
      check(rail_en, 1'b1, "sequence restart");
      uv = 1'b0;
      wait_for(1, 1'b1, 6000, n);
      drive_a = 1'b1;
      wait_for(0, 1'b0, 3000, n);
      check(n >= 2090 && n <= 2140, 1'b1, "trigger wait");
      drive_a = 1'b0;
      wait_for(0, 1'b1, 700, n);
      check(n >= 490 && n <= 520, 1'b1, "hard off");
      wait_for(1, 1'b1, 6000, n);
      mode = 4'h8 | 4'($urandom);
      shutdown = 1'b1;
      cycles(2);
      shutdown = 1'b0;
      check(rail_en, 1'b1, "reserved shutdown");
      $display("mode 2 test done");
      mode = 4'h7;
      cycles(2);
      shutdown = 1'b1;
      cycles(1);
      shutdown = 1'b0;
      wait_for(0, 1'b0, 400, n);
      check(n >= 290 && n <= 305, 1'b1, "shutdown delay");
      $display("mode 7 test done");
      print_verdict();
   end
endmodule
